// >>> design/tic_timer.sv
// 16-bit free-running timer with alternate count view and input capture
`timescale 1ns/1ps

module tic_timer
	import tic_pkg::*;
(
	// clock and resets
	input  wire logic        mclk,
	input  wire logic        rst_b,
	input  wire logic        por_b,
	// avalon-mm slave, word addressed
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// power mode
	input  wire logic        stop_mode,
	// capture pin and shared port
	input  wire logic        shared_port_pin_in,
	input  wire logic        comparator_out,
	input  wire logic        port_data_bit,
	input  wire logic        port_dir_out,
	output logic             shared_port_pin_out,
	output logic             shared_port_pin_oe_b,
	output logic             port_read_bit,
	output logic             comparator_enable,
	// timer interrupt request
	output logic             timer_irq
);

	// low byte view: frozen copy or live counter byte
	function automatic logic [7:0] lo_view(input logic frozen,
		input logic [7:0] hold, input logic [7:0] live);
		lo_view = frozen ? hold : live;
	endfunction

	// counter and prescaler state
	logic [15:0] cnt;          // free-running count
	logic [1:0]  presc;        // divide-by-four prescaler
	logic [11:0] start_cnt;    // start-up delay counter
	// control and status
	tic_ctrl_s   ctrl;         // enables and edge select
	logic        cap_flag;     // capture event flag
	logic        ovf_flag;     // overflow event flag
	logic        cf_arm;       // status seen with capture flag set
	logic        of_arm;       // status seen with overflow flag set
	// latches for the two count views
	logic        alt_frozen;   // alternate low byte held
	logic [7:0]  alt_hold;     // alternate low byte copy
	logic        pri_frozen;   // primary low byte held
	logic [7:0]  pri_hold;     // primary low byte copy
	// capture path
	logic [15:0] cap_val;      // captured count
	logic        cap_block;    // capture high read, low pending
	logic        cap_q;        // previous capture level
	logic        cap_primed;   // cap_q valid after reset
	logic        armed;        // edge seen while stopped
	logic [15:0] arm_val;      // count plus one taken at that edge
	logic        stop_q;       // stop_mode one cycle ago

	// bus handshake: reads act on the first edge, writes on the
	// edge where waitrequest is low, so both see a steady request
	wire rd_take = avs_read & avs_waitrequest;
	wire wr_take = avs_write & ~avs_waitrequest;
	wire req     = avs_read | avs_write;

	// address decode
	wire hit_ctrl   = avs_address == TIC_CTRL_IDX;
	wire hit_status = avs_address == TIC_STATUS_IDX;
	wire hit_caph   = avs_address == TIC_CAPH_IDX;
	wire hit_capl   = avs_address == TIC_CAPL_IDX;
	wire hit_prih   = avs_address == TIC_PRIH_IDX;
	wire hit_pril   = avs_address == TIC_PRIL_IDX;
	wire hit_alth   = avs_address == TIC_ALTH_IDX;
	wire hit_altl   = avs_address == TIC_ALTL_IDX;
	wire hit_cisel  = avs_address == TIC_CISEL_IDX;

	// read and write strobes per register
	wire rd_status = rd_take & hit_status;
	wire rd_caph   = rd_take & hit_caph;
	wire rd_capl   = rd_take & hit_capl;
	wire rd_prih   = rd_take & hit_prih;
	wire acc_pril  = (rd_take | wr_take) & hit_pril;
	wire rd_alth   = rd_take & hit_alth;
	wire rd_altl   = rd_take & hit_altl;
	wire wr_ctrl   = wr_take & hit_ctrl;
	wire wr_cisel  = wr_take & hit_cisel;
	wire [7:0] wbyte = avs_writedata[7:0];

	// counter timing
	wire started = start_cnt == TIC_STARTUP_CYCLES;
	wire run     = started & ~stop_mode;
	wire tick    = run & (presc == TIC_PRESC_LAST);
	wire wrap    = tick & (cnt == TIC_CNT_MAX);

	// capture source and edge detection
	wire cap_src  = comparator_enable ? comparator_out
		: shared_port_pin_in;
	wire cap_edge = cap_primed & (cap_q != cap_src)
		& (cap_src == ctrl.capture_edge_select);
	wire wake     = stop_q & ~stop_mode;
	wire live_cap = cap_edge & ~stop_mode;
	wire take_arm = wake & armed & ~cap_block;
	wire take_liv = live_cap & ~cap_block & ~(wake & armed);
	wire cap_set  = live_cap | (wake & armed);
	wire [15:0] cnt_next_val = cnt + TIC_CNT_ONE;

	// register byte images
	// widen before shifting so no bit is lost to a 1-bit shift
	wire [7:0] ctrl_byte = (8'(ctrl.cie) << TIC_BIT_CIE)
		| (8'(ctrl.oie) << TIC_BIT_OIE)
		| (8'(ctrl.capture_edge_select) << TIC_BIT_CAPTURE_EDGE_SELECT);
	wire [7:0] status_byte = (8'(cap_flag) << TIC_BIT_CF)
		| (8'(ovf_flag) << TIC_BIT_OF);
	wire [7:0] cisel_byte = 8'(comparator_enable) << TIC_BIT_CISEL;

	// read mux; unmapped indices read as zero
	wire [7:0] rd_byte =
		hit_ctrl   ? ctrl_byte :
		hit_status ? status_byte :
		hit_caph   ? cap_val[15:8] :
		hit_capl   ? cap_val[7:0] :
		hit_prih   ? cnt[15:8] :
		hit_pril   ? lo_view(pri_frozen, pri_hold, cnt[7:0]) :
		hit_alth   ? cnt[15:8] :
		hit_altl   ? lo_view(alt_frozen, alt_hold, cnt[7:0]) :
		hit_cisel  ? cisel_byte : 8'h00;

	// one wait state for every access
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= TIC_RDATA_RESET;
		end else begin
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (rd_take) begin
				avs_readdata <= {TIC_RDATA_PAD, rd_byte};
			end
		end
	end

	// start-up delay, prescaler and counter; reads never reach here
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cnt       <= TIC_CNT_PRESET;
			presc     <= 2'h0;
			start_cnt <= 12'h000;
		end else begin
			if (!started) begin
				start_cnt <= start_cnt + 12'h001;
			end
			// stop freezes both prescaler and counter
			if (run) begin
				presc <= presc + 2'h1;
			end
			if (tick) begin
				cnt <= cnt_next_val;
			end
		end
	end

	// alternate view latch; writes never reach it
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			alt_frozen <= 1'b0;
			alt_hold   <= 8'h00;
		end else if (rd_alth && !alt_frozen) begin
			alt_frozen <= 1'b1;
			alt_hold   <= cnt[7:0];
		end else if (rd_altl) begin
			alt_frozen <= 1'b0;
		end
	end

	// primary view latch, same scheme, but a low byte write also releases it
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			pri_frozen <= 1'b0;
			pri_hold   <= 8'h00;
		end else if (rd_prih && !pri_frozen) begin
			pri_frozen <= 1'b1;
			pri_hold   <= cnt[7:0];
		end else if (acc_pril) begin
			pri_frozen <= 1'b0;
		end
	end

	// enables cleared by device reset
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			ctrl.cie <= 1'b0;
			ctrl.oie <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl.cie <= wbyte[TIC_BIT_CIE];
			ctrl.oie <= wbyte[TIC_BIT_OIE];
		end
		// edge select survives device reset, only power-on clears it
		if (!por_b) begin
			ctrl.capture_edge_select <= 1'b0;
		end else if (rst_b && wr_ctrl) begin
			ctrl.capture_edge_select <= wbyte[TIC_BIT_CAPTURE_EDGE_SELECT];
		end
	end

	// capture input select; also powers the comparator reference
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			comparator_enable <= 1'b0;
		end else if (wr_cisel) begin
			comparator_enable <= wbyte[TIC_BIT_CISEL];
		end
	end

	// edge detector history; primed so reset cannot fake an edge
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cap_q      <= 1'b0;
			cap_primed <= 1'b0;
			stop_q     <= 1'b0;
		end else begin
			cap_q      <= cap_src;
			cap_primed <= 1'b1;
			stop_q     <= stop_mode;
		end
	end

	// first edge in stop is parked; a reset throws it away
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			armed   <= 1'b0;
			arm_val <= 16'h0000;
		end else if (stop_mode && cap_edge && !armed) begin
			armed   <= 1'b1;
			arm_val <= cnt_next_val;
		end else if (wake) begin
			armed   <= 1'b0;
		end
	end

	// capture block: high read stops transfers until low read
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cap_block <= 1'b0;
		end else if (rd_caph) begin
			cap_block <= 1'b1;
		end else if (rd_capl) begin
			cap_block <= 1'b0;
		end
	end

	// capture data: untouched by device reset, newest wins except at wake, where the parked edge beats a live one
	always_ff @(posedge mclk) begin
		if (!por_b) begin
			cap_val <= 16'h0000;
		end else if (take_arm) begin
			cap_val <= arm_val;
		end else if (take_liv) begin
			cap_val <= cnt_next_val;
		end
	end

	// flags: set beats clear; only power-on resets them
	always_ff @(posedge mclk) begin
		if (!por_b) begin
			cap_flag <= 1'b0;
			ovf_flag <= 1'b0;
			cf_arm   <= 1'b0;
			of_arm   <= 1'b0;
		end else begin
			if (cap_set) begin
				cap_flag <= 1'b1;
			end else if (rd_capl && cf_arm) begin
				cap_flag <= 1'b0;
			end
			if (wrap) begin
				ovf_flag <= 1'b1;
			end else if (acc_pril && of_arm) begin
				ovf_flag <= 1'b0;
			end
			// the clear needs a status read that saw the flag
			if (rd_status && cap_flag) begin
				cf_arm <= 1'b1;
			end else if (rd_capl) begin
				cf_arm <= 1'b0;
			end
			if (rd_status && ovf_flag) begin
				of_arm <= 1'b1;
			end else if (acc_pril) begin
				of_arm <= 1'b0;
			end
		end
	end

	// interrupt request from enabled flags
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			timer_irq <= 1'b0;
		end else begin
			timer_irq <= (cap_flag & ctrl.cie)
				| (ovf_flag & ctrl.oie);
		end
	end

	// shared port pin; comparator mode forces it to input
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			shared_port_pin_oe_b <= 1'b1;
			shared_port_pin_out  <= 1'b0;
			port_read_bit        <= 1'b0;
		end else begin
			shared_port_pin_oe_b <= ~(port_dir_out
				& ~comparator_enable);
			shared_port_pin_out  <= port_data_bit;
			port_read_bit <= comparator_enable ? comparator_out
				: (port_dir_out ? port_data_bit
				: shared_port_pin_in);
		end
	end

	// checks
	default clocking cb @(posedge mclk); endclocking

	sequence s_status_cf;
		rd_status && cap_flag;
	endsequence

	sequence s_armed_capl;
		rd_capl && cf_arm && !cap_set;
	endsequence

	cnt_preset_a: assert property (
		disable iff (1'b0) !rst_b |=> cnt == TIC_CNT_PRESET)
		else $error("counter not preset after reset");

	presc_gap_a: assert property (
		disable iff (!rst_b) tick |=> !tick [*3])
		else $error("counter advanced faster than every four");

	stop_hold_a: assert property (
		disable iff (!rst_b) stop_mode |=> cnt == $past(cnt))
		else $error("counter moved in stop");

	alt_freeze_a: assert property (
		disable iff (!rst_b) (alt_frozen && !rd_altl)
		|=> alt_frozen && alt_hold == $past(alt_hold))
		else $error("alternate low byte not frozen");

	cap_plus_one_a: assert property (
		disable iff (!por_b) take_liv
		|=> cap_val == $past(cnt) + TIC_CNT_ONE)
		else $error("capture not one above count");

	cap_block_a: assert property (
		disable iff (!por_b) (cap_block && !wake)
		|=> cap_val == $past(cap_val))
		else $error("capture taken while blocked");

	cf_arm_a: assert property (
		disable iff (!por_b) s_status_cf |=> cf_arm)
		else $error("status read did not arm clear");

	cf_clear_a: assert property (
		disable iff (!por_b) s_armed_capl |=> !cap_flag)
		else $error("capture flag not cleared");

	ovf_set_a: assert property (
		disable iff (!por_b) wrap |=> ovf_flag && cnt == 16'h0000)
		else $error("overflow flag not set on wrap");

	ctrl_reset_a: assert property (
		disable iff (1'b0) (!rst_b && por_b)
		|=> !ctrl.cie && !ctrl.oie && ctrl.capture_edge_select == $past(ctrl.capture_edge_select))
		else $error("control reset wrong");

	stop_quiet_a: assert property (
		disable iff (!por_b) (stop_mode && !cap_flag) |=> !cap_flag)
		else $error("flag set while stopped");

	irq_follow_a: assert property (
		disable iff (!rst_b) ((cap_flag && ctrl.cie)
		|| (ovf_flag && ctrl.oie)) |=> timer_irq)
		else $error("interrupt missing for enabled flag");

endmodule

// >>> common/tic_pkg.sv
// shared constants and types for the 16-bit capture timer
package tic_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] TIC_CTRL_IDX   = 8'h12;
	localparam logic [7:0] TIC_STATUS_IDX = 8'h13;
	localparam logic [7:0] TIC_CAPH_IDX   = 8'h14;
	localparam logic [7:0] TIC_CAPL_IDX   = 8'h15;
	localparam logic [7:0] TIC_PRIH_IDX   = 8'h18;
	localparam logic [7:0] TIC_PRIL_IDX   = 8'h19;
	localparam logic [7:0] TIC_ALTH_IDX   = 8'h1A;
	localparam logic [7:0] TIC_ALTL_IDX   = 8'h1B;
	localparam logic [7:0] TIC_CISEL_IDX  = 8'h1C;

	// field positions in status and control bytes
	localparam int TIC_BIT_CF    = 7;
	localparam int TIC_BIT_OF    = 5;
	localparam int TIC_BIT_CIE   = 7;
	localparam int TIC_BIT_OIE   = 5;
	localparam int TIC_BIT_CAPTURE_EDGE_SELECT  = 1;
	localparam int TIC_BIT_CISEL = 0;

	// counter values
	localparam logic [15:0] TIC_CNT_PRESET = 16'hFFFC;
	localparam logic [15:0] TIC_CNT_MAX    = 16'hFFFF;
	localparam logic [15:0] TIC_CNT_ONE    = 16'h0001;
	localparam logic [1:0]  TIC_PRESC_LAST = 2'h3;

	// bus cycles before the counter may run after a reset
	localparam logic [11:0] TIC_STARTUP_CYCLES = 12'h0FE0;

	// data bus reset and padding values
	localparam logic [31:0] TIC_RDATA_RESET = 32'h0000_0000;
	localparam logic [23:0] TIC_RDATA_PAD   = 24'h00_0000;

	// timer control bits that steer the block
	typedef struct packed {
		logic cie;   // capture interrupt enable
		logic oie;   // overflow interrupt enable
		logic capture_edge_select;  // capture edge select, 1 = rising
	} tic_ctrl_s;

endpackage

// >>> bench/tic_cpu_model.sv
// cpu side avalon-mm master that issues the register accesses
`timescale 1ns/1ps

module tic_cpu_model
	import tic_pkg::*;
(
	// clock
	input  wire logic        mclk,
	// avalon-mm master
	output logic      [7:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	input  wire logic        avs_waitrequest,
	// set when an answer never came
	output logic             hung
);
	// idle bus from time zero
	initial begin
		avs_address = 8'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		hung = 1'b0;
	end

	// one access, held until waitrequest is seen low; bounded wait
	task automatic acc(input logic wr, input logic [7:0] idx,
		input logic [7:0] dat);
		int n;
		n = 0;
		avs_address <= idx;
		avs_writedata <= {TIC_RDATA_PAD, dat};
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		// released data is scrambled so nothing leans on stale bits
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~avs_writedata;
		hung <= (n >= 64);
		// idle cycle so the next request is a fresh assignment
		@(posedge mclk);
	endtask
endmodule

// >>> bench/timer16_alt_count_input_capture_test.sv
// self-checking bench for the capture timer
`timescale 1ns/1ps

module timer16_alt_count_input_capture_test
	import tic_pkg::*;
;
	// clock, resets, power mode
	logic        mclk;
	logic        rst_b;
	logic        por_b;
	logic        stop_mode;
	// pin side stimulus
	logic        pin_in;
	logic        cmp_out;
	logic        port_data;
	logic        port_dir;
	// bus between model and design
	wire  [7:0]  avs_address;
	wire         avs_read;
	wire         avs_write;
	wire  [31:0] avs_writedata;
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest;
	wire         hung;
	// design pin outputs
	wire         pin_out;
	wire         pin_oe_b;
	wire         port_read;
	wire         cmp_en;
	wire         timer_irq;
	// bookkeeping: notes hold {care mask, expected byte}
	int          n_tests = 0;
	int          n_mismatch = 0;
	logic [15:0] expq[$];
	logic [15:0] note;
	logic [31:0] r;
	logic        e;
	logic        hit;

	tic_cpu_model i_cpu (
		.mclk(mclk),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_waitrequest(avs_waitrequest),
		.hung(hung)
	);

	tic_timer i_dut (
		.mclk(mclk),
		.rst_b(rst_b),
		.por_b(por_b),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.stop_mode(stop_mode),
		.shared_port_pin_in(pin_in),
		.comparator_out(cmp_out),
		.port_data_bit(port_data),
		.port_dir_out(port_dir),
		.shared_port_pin_out(pin_out),
		.shared_port_pin_oe_b(pin_oe_b),
		.port_read_bit(port_read),
		.comparator_enable(cmp_en),
		.timer_irq(timer_irq)
	);

	// 250 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// read returns are matched to the oldest note
	always @(posedge mclk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			note = expq.pop_front();
			cmp(avs_readdata & {24'hFF_FFFF, note[15:8]},
				{24'h00_0000, note[7:0] & note[15:8]});
		end
	end

	// a bus wait that ran out ends the run
	always @(posedge mclk) begin
		if (hung === 1'b1) begin
			n_mismatch++;
			summarize();
		end
	end

	// overall guard against a hang anywhere
	initial begin
		repeat (100000) @(posedge mclk);
		n_mismatch++;
		summarize();
	end

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
		input logic [7:0] m);
		expq.push_back({m, exp});
		i_cpu.acc(1'b0, idx, 8'h00);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
		i_cpu.acc(1'b1, idx, dat);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic tend(input string s);
		$display("test done: %s", s);
	endtask

	// device reset only; power-on state is kept
	task automatic do_reset;
		rst_b <= 1'b0;
		tick(10);
		rst_b <= 1'b1;
		tick(1);
	endtask

	initial begin
		rst_b = 1'b0;
		por_b = 1'b0;
		stop_mode = 1'b0;
		pin_in = 1'b0;
		cmp_out = 1'b0;
		port_data = 1'b0;
		port_dir = 1'b1;
		r = $urandom(36);
		tick(10);
		rst_b <= 1'b1;
		por_b <= 1'b1;
		tick(1);
		// counter sits at its preset during start-up
		rd(TIC_CTRL_IDX, 8'h00, 8'hFF);
		rd(TIC_STATUS_IDX, 8'h00, 8'hFF);
		rd(TIC_ALTH_IDX, 8'hFF, 8'hFF);
		rd(TIC_ALTL_IDX, 8'hFC, 8'hFF);
		r = $urandom;
		wr(TIC_ALTH_IDX, r[7:0]);
		wr(TIC_ALTL_IDX, r[15:8]);
		wr(TIC_STATUS_IDX, 8'hFF);
		rd(TIC_ALTH_IDX, 8'hFF, 8'hFF);
		rd(TIC_ALTL_IDX, 8'hFC, 8'hFF);
		rd(TIC_STATUS_IDX, 8'h00, 8'hFF);
		tend("reset values");
		// four toggles cover both edges under both selections
		for (int k = 0; k < 4; k++) begin
			e = k[1];
			wr(TIC_CTRL_IDX, {6'h20, e, 1'b0});
			rd(TIC_CTRL_IDX, {6'h20, e, 1'b0}, 8'hFF);
			pin_in <= !pin_in;
			tick(6);
			hit = (pin_in === e);
			cmp(32'(timer_irq), 32'(hit));
			rd(TIC_STATUS_IDX, {hit, 7'h00}, 8'hFF);
			rd(TIC_CAPH_IDX, 8'hFF, {8{hit}});
			rd(TIC_CAPL_IDX, 8'hFD, {8{hit}});
			rd(TIC_STATUS_IDX, 8'h00, 8'hFF);
		end
		wr(TIC_CAPL_IDX, r[7:0]);
		do_reset();
		rd(TIC_CAPH_IDX, 8'hFF, 8'hFF);
		rd(TIC_CAPL_IDX, 8'hFD, 8'hFF);
		rd(TIC_CTRL_IDX, 8'h02, 8'hFF);
		tend("capture edges");
		// blocked capture across the first wrap, frozen low byte
		wr(TIC_CTRL_IDX, 8'hA2);
		rd(TIC_ALTH_IDX, 8'hFF, 8'hFF);
		pin_in <= 1'b1;
		tick(6);
		rd(TIC_CAPH_IDX, 8'hFF, 8'hFF);
		tick(4200);
		rd(TIC_ALTL_IDX, 8'hFC, 8'hFF);
		pin_in <= 1'b0;
		tick(4);
		pin_in <= 1'b1;
		tick(6);
		rd(TIC_STATUS_IDX, 8'hA0, 8'hFF);
		rd(TIC_ALTH_IDX, 8'h00, 8'h00);
		rd(TIC_ALTL_IDX, 8'h00, 8'h00);
		rd(TIC_STATUS_IDX, 8'hA0, 8'hFF);
		rd(TIC_CAPL_IDX, 8'hFD, 8'hFF);
		rd(TIC_STATUS_IDX, 8'h20, 8'hFF);
		rd(TIC_PRIL_IDX, 8'h00, 8'h00);
		rd(TIC_STATUS_IDX, 8'h00, 8'hFF);
		tick(3);
		cmp(32'(timer_irq), 32'h0000_0000);
		tend("blocking and overflow");
		// edge while stopped is parked until wake
		pin_in <= 1'b0;
		tick(2);
		stop_mode <= 1'b1;
		tick(2);
		pin_in <= 1'b1;
		tick(6);
		cmp(32'(timer_irq), 32'h0000_0000);
		stop_mode <= 1'b0;
		tick(6);
		cmp(32'(timer_irq), 32'h0000_0001);
		rd(TIC_STATUS_IDX, 8'h80, 8'hFF);
		rd(TIC_CAPL_IDX, 8'h00, 8'h00);
		rd(TIC_STATUS_IDX, 8'h00, 8'hFF);
		// reset out of stop drops the parked edge
		stop_mode <= 1'b1;
		pin_in <= 1'b0;
		tick(2);
		pin_in <= 1'b1;
		tick(4);
		do_reset();
		stop_mode <= 1'b0;
		tick(6);
		rd(TIC_STATUS_IDX, 8'h00, 8'hFF);
		rd(TIC_ALTH_IDX, 8'hFF, 8'hFF);
		rd(TIC_ALTL_IDX, 8'hFC, 8'hFF);
		tend("stop mode");
		// input select steers the shared pin
		for (int k = 0; k < 8; k++) begin
			r = $urandom;
			wr(TIC_CISEL_IDX, {r[7:1], k[2]});
			rd(TIC_CISEL_IDX, {7'h00, k[2]}, 8'h01);
			port_data <= r[8];
			cmp_out <= r[9];
			port_dir <= r[10];
			tick(3);
			cmp(32'(cmp_en), 32'(k[2]));
			cmp(32'(pin_oe_b), 32'(k[2] | !r[10]));
			cmp(32'(pin_out), 32'(r[8]));
			// comparator wins, else output data, else the pin level
			hit = k[2] ? r[9] : (r[10] ? r[8] : pin_in);
			cmp(32'(port_read), 32'(hit));
		end
		tend("shared pin");
		summarize();
	end
endmodule
